// ---- src/umc_pkg.sv ----
// Purpose: Shared constants for the modem control and auto flow block.
// Assumes: One 100 MHz clock domain, synchronous active-low reset.
// Notes: Register addresses are full 32-bit byte addresses.
package umc_pkg;

  // Register byte addresses.
  localparam logic [31:0] UMC_MLC_ADDR = 32'h80101010;
  localparam logic [31:0] UMC_EVT_STAT_ADDR = 32'h80101040;
  localparam logic [31:0] UMC_EVT_CLR_ADDR = 32'h80101044;
  localparam logic [31:0] UMC_EVT_EN_ADDR = 32'h80101048;

  // Field positions of modem_line_control.
  localparam int UMC_DTR_BIT = 0;
  localparam int UMC_RTS_BIT = 1;
  localparam int UMC_OUT1_BIT = 2;
  localparam int UMC_OUT2_BIT = 3;
  localparam int UMC_LOOP_BIT = 4;
  localparam int UMC_ARTS_BIT = 6;
  localparam int UMC_ACTS_BIT = 7;

  // Reset value and the bits that are stored at all.
  localparam logic [7:0] UMC_MLC_RST = 8'h00;
  localparam logic [7:0] UMC_MLC_STORE_MASK = 8'hdf;

  // Event bits: 3:0 modem input deltas, 4 auto RTS negation.
  localparam int UMC_EVT_W = 5;
  localparam int UMC_EVT_RTS_BIT = 4;
  localparam logic [4:0] UMC_EVT_RST = 5'h00;

  // Receive FIFO level width and trigger thresholds.
  localparam int UMC_LVL_W = 6;
  localparam logic [5:0] UMC_TRIG_C0 = 6'h01;
  localparam logic [5:0] UMC_TRIG_C1 = 6'h10;
  localparam logic [5:0] UMC_TRIG_C2 = 6'h18;
  localparam logic [5:0] UMC_TRIG_C3 = 6'h1c;
  localparam logic [5:0] UMC_LVL_EMPTY = 6'h00;

  // Pin synchroniser idle value {dcd,ri,dsr,cts,rxd}.
  localparam logic [4:0] UMC_PIN_IDLE = 5'h1f;

  // AXI response codes.
  localparam logic [1:0] UMC_RESP_OKAY = 2'h0;
  localparam logic [1:0] UMC_RESP_SLVERR = 2'h2;

endpackage : umc_pkg

// ---- src/umc_flow_if.sv ----
// Purpose: Carries FIFO level and auto RTS state between modules.
// Assumes: Both ends sit on the same clock.
// Notes: The control end drives inputs, the flow end the verdict.
interface umc_flow_if;
  import umc_pkg::*;
  logic [UMC_LVL_W-1:0] rx_level; // Receive FIFO occupancy.
  logic [1:0] rx_trig; // Trigger field of fifo_setup.
  logic enable; // auto_request_flow_enable.
  logic rts_negate; // High while RTS must be high.
  modport ctrl (output rx_level, output rx_trig, output enable,
    input rts_negate);
  modport flow (input rx_level, input rx_trig, input enable,
    output rts_negate);
endinterface : umc_flow_if

// ---- src/umc_autoflow.sv ----
// Purpose: Decides when automatic RTS flow control negates RTS.
// Assumes: FIFO level comes from logic on the same clock.
// Notes: Hysteresis runs between the trigger and the level below.
module umc_autoflow
  import umc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  umc_flow_if.flow fl
);

  // Threshold in characters for a trigger code.
  function automatic logic [UMC_LVL_W-1:0] trig_count(
    input logic [1:0] sel);
    case (sel)
      2'h0: trig_count = UMC_TRIG_C0;
      2'h1: trig_count = UMC_TRIG_C1;
      2'h2: trig_count = UMC_TRIG_C2;
      default: trig_count = UMC_TRIG_C3;
    endcase
  endfunction

  // Level at which RTS comes back; the lowest code has none below.
  function automatic logic [UMC_LVL_W-1:0] low_count(
    input logic [1:0] sel);
    if (sel == 2'h0) begin
      low_count = UMC_LVL_EMPTY;
    end else begin
      low_count = trig_count(sel - 2'h1);
    end
  endfunction

  logic rts_negate_r; // Registered negation verdict.

  // Set at the trigger, clear at the level below, idle when off.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rts_negate_r <= 1'b0;
    end else if (!fl.enable) begin
      rts_negate_r <= 1'b0;
    end else if (fl.rx_level >= trig_count(fl.rx_trig)) begin
      rts_negate_r <= 1'b1;
    end else if (fl.rx_level <= low_count(fl.rx_trig)) begin
      rts_negate_r <= 1'b0;
    end
  end

  assign fl.rts_negate = rts_negate_r;

endmodule // umc_autoflow

// ---- src/umc_modem_ctrl.sv ----
// Purpose: Modem control register, loopback and auto flow control.
// Assumes: AXI4-Lite master on aclk; pins are asynchronous.
// Notes: Every output of this module comes straight from a flop.
//
// Added by the designer: register access over AXI4-Lite.
module umc_modem_ctrl
  import umc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave.
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Rest of the UART, same clock.
  input wire logic [UMC_LVL_W-1:0] rx_level,
  input wire logic [1:0] rx_trig,
  input wire logic tx_serial,
  output logic rx_serial,
  output logic tx_start_ok,
  output logic [3:0] modem_line_state,
  // Pins, active low where named so.
  input wire logic rxd_pin,
  input wire logic cts_n_pin,
  input wire logic dsr_n_pin,
  input wire logic ri_n_pin,
  input wire logic dcd_n_pin,
  output logic txd_pin,
  output logic rts_n_pin,
  output logic dtr_n_pin,
  output logic irq
);

  // True when an address names one of this block's registers.
  function automatic logic addr_hit(input logic [31:0] a);
    addr_hit = (a == UMC_MLC_ADDR) || (a == UMC_EVT_STAT_ADDR) ||
      (a == UMC_EVT_CLR_ADDR) || (a == UMC_EVT_EN_ADDR);
  endfunction

  // Bus side state.
  logic awready_r; // Write address channel open.
  logic wready_r; // Write data channel open.
  logic aw_held_r; // A write address waits for its data.
  logic w_held_r; // Write data wait for their address.
  logic [31:0] aw_addr_r; // Held write address.
  logic [31:0] w_data_r; // Held write data.
  logic [3:0] w_strb_r; // Held byte enables.
  logic bvalid_r; // Write response pending.
  logic [1:0] bresp_r; // Write response code.
  logic arready_r; // Read address channel open.
  logic rvalid_r; // Read data pending.
  logic [31:0] rdata_r; // Read data word.
  logic [1:0] rresp_r; // Read response code.
  logic wr_fire; // Both halves of a write are held.
  logic [31:0] rd_word; // Read multiplexer output.

  // Register state.
  logic [7:0] mlc_r; // Stored modem_line_control bits.
  logic [UMC_EVT_W-1:0] evt_stat_r; // Sticky event bits.
  logic [UMC_EVT_W-1:0] evt_en_r; // Event enables.
  logic [UMC_EVT_W-1:0] evt_clr; // Clear pulse from the bus.
  logic [UMC_EVT_W-1:0] evt_set; // Events seen this cycle.
  logic [UMC_EVT_W-1:0] evt_nxt; // Next sticky value.

  // Pin and modem state.
  logic [4:0] pin_meta_r; // First synchroniser stage.
  logic [4:0] pin_sync_r; // Second stage, the only one read.
  logic [3:0] ext_in; // {dcd,ri,dsr,cts} from pins, active high.
  logic [3:0] loop_in; // Same set fed from the control bits and internal RTS.
  logic [3:0] mls_nxt; // Next modem_line_state.
  logic [3:0] mls_r; // Current modem_line_state.
  logic rts_int; // Internal RTS, active high.
  logic rts_neg_prev_r; // Last auto negation for edge detection.
  logic txd_r;
  logic rx_serial_r;
  logic rts_n_r;
  logic dtr_n_r;
  logic tx_start_ok_r;
  logic irq_r;
  logic loop_on; // Loopback selected.
  logic arts_on; // auto_request_flow_enable.
  logic acts_on; // auto_clear_flow_enable.

  umc_flow_if flow_bus ();

  assign loop_on = mlc_r[UMC_LOOP_BIT];
  assign arts_on = mlc_r[UMC_ARTS_BIT];
  assign acts_on = mlc_r[UMC_ACTS_BIT];

  // Hand the FIFO level and trigger field to the flow decider.
  assign flow_bus.rx_level = rx_level;
  assign flow_bus.rx_trig = rx_trig;
  assign flow_bus.enable = arts_on;

  umc_autoflow u_autoflow (
    .aclk (aclk),
    .aresetn (aresetn),
    .fl (flow_bus.flow)
  );

  // Write address channel: take once, reopen after the response.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      aw_held_r <= 1'b0;
      aw_addr_r <= 32'h0;
    end else begin
      if (s_axi_awvalid && awready_r) begin
        awready_r <= 1'b0;
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (bvalid_r && s_axi_bready) begin
        awready_r <= 1'b1;
        aw_held_r <= 1'b0;
      end
    end
  end

  // Write data channel, independent of the address so either may lead.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_r <= 1'b1;
      w_held_r <= 1'b0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
    end else begin
      if (s_axi_wvalid && wready_r) begin
        wready_r <= 1'b0;
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (bvalid_r && s_axi_bready) begin
        wready_r <= 1'b1;
        w_held_r <= 1'b0;
      end
    end
  end

  // A write takes effect in the first cycle both halves are held.
  assign wr_fire = aw_held_r && w_held_r && !bvalid_r;

  // Write response; unmapped addresses answer with a slave error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= UMC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      if (addr_hit(aw_addr_r)) begin
        bresp_r <= UMC_RESP_OKAY;
      end else begin
        bresp_r <= UMC_RESP_SLVERR;
      end
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Control register write. Every field lives in byte lane 0.
  // Reserved bits 3:2 are kept so loopback can use them.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mlc_r <= UMC_MLC_RST;
    end else if (wr_fire && aw_addr_r == UMC_MLC_ADDR &&
                 w_strb_r[0]) begin
      mlc_r <= w_data_r[7:0] & UMC_MLC_STORE_MASK;
      if (arts_on) begin
        // The RTS bit belongs to the FIFO while auto RTS is on.
        mlc_r[UMC_RTS_BIT] <= mlc_r[UMC_RTS_BIT];
      end
    end
  end

  // Event enable register, same layout as the status register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_en_r <= UMC_EVT_RST;
    end else if (wr_fire && aw_addr_r == UMC_EVT_EN_ADDR &&
                 w_strb_r[0]) begin
      evt_en_r <= w_data_r[UMC_EVT_W-1:0];
    end
  end

  // Clear pulse: writing a one to the clear register drops that bit.
  always_comb begin
    evt_clr = UMC_EVT_RST;
    if (wr_fire && aw_addr_r == UMC_EVT_CLR_ADDR && w_strb_r[0]) begin
      evt_clr = w_data_r[UMC_EVT_W-1:0];
    end
  end

  // Read multiplexer. The RTS bit shows the live pin under auto RTS,
  // and zero in loopback; write-only and unmapped words read zero.
  always_comb begin
    rd_word = 32'h0;
    case (s_axi_araddr)
      UMC_MLC_ADDR: begin
        rd_word[UMC_LOOP_BIT] = mlc_r[UMC_LOOP_BIT];
        rd_word[UMC_ARTS_BIT] = mlc_r[UMC_ARTS_BIT];
        rd_word[UMC_ACTS_BIT] = mlc_r[UMC_ACTS_BIT];
        if (loop_on) begin
          rd_word[UMC_RTS_BIT] = 1'b0;
        end else if (arts_on) begin
          rd_word[UMC_RTS_BIT] = ~rts_n_r;
        end else begin
          rd_word[UMC_RTS_BIT] = mlc_r[UMC_RTS_BIT];
        end
      end
      UMC_EVT_STAT_ADDR: rd_word[UMC_EVT_W-1:0] = evt_stat_r;
      UMC_EVT_EN_ADDR: rd_word[UMC_EVT_W-1:0] = evt_en_r;
      default: rd_word = 32'h0;
    endcase
  end

  // Read channel: one read under way, data registered at the take.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= UMC_RESP_OKAY;
    end else if (s_axi_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      if (addr_hit(s_axi_araddr)) begin
        rresp_r <= UMC_RESP_OKAY;
      end else begin
        rresp_r <= UMC_RESP_SLVERR;
      end
    end else if (rvalid_r && s_axi_rready) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
    end
  end

  // Two flops on every pin before anything looks at it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_r <= UMC_PIN_IDLE;
      pin_sync_r <= UMC_PIN_IDLE;
    end else begin
      pin_meta_r <= {dcd_n_pin, ri_n_pin, dsr_n_pin, cts_n_pin, rxd_pin};
      pin_sync_r <= pin_meta_r;
    end
  end

  // Internal RTS follows the FIFO under auto RTS, else the bit.
  assign rts_int = arts_on ? ~flow_bus.rts_negate : mlc_r[UMC_RTS_BIT];

  // Modem inputs come from pins, or in loopback from control bits and internal RTS.
  assign ext_in = ~pin_sync_r[4:1];
  assign loop_in = {mlc_r[UMC_OUT2_BIT], mlc_r[UMC_OUT1_BIT],
    mlc_r[UMC_DTR_BIT], rts_int};
  assign mls_nxt = loop_on ? loop_in : ext_in;

  // Modem state towards the status logic elsewhere in the UART.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mls_r <= 4'h0;
      rts_neg_prev_r <= 1'b0;
    end else begin
      mls_r <= mls_nxt;
      rts_neg_prev_r <= flow_bus.rts_negate;
    end
  end

  // Any change of a modem input is an event, whatever its source, so
  // loopback writes raise the same events pin changes would.
  always_comb begin
    evt_set = UMC_EVT_RST;
    evt_set[3:0] = mls_r ^ mls_nxt;
    evt_set[UMC_EVT_RTS_BIT] = flow_bus.rts_negate & ~rts_neg_prev_r;
  end

  // Sticky status: a set in the clearing cycle wins over the clear.
  assign evt_nxt = (evt_stat_r & ~evt_clr) | evt_set;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_stat_r <= UMC_EVT_RST;
      irq_r <= 1'b0;
    end else begin
      evt_stat_r <= evt_nxt;
      irq_r <= |(evt_nxt & evt_en_r);
    end
  end

  // Serial paths. In loopback the transmitter feeds the receiver and
  // the line stays marking; the RXD pin is then ignored.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txd_r <= 1'b1;
      rx_serial_r <= 1'b1;
    end else if (loop_on) begin
      txd_r <= 1'b1;
      rx_serial_r <= tx_serial;
    end else begin
      // A stalled transmitter idles high, so TXD marks until resumed.
      txd_r <= tx_serial;
      rx_serial_r <= pin_sync_r[0];
    end
  end

  // Modem outputs. RTS is driven low for a stored one while auto RTS is off; loopback
  // parks both outputs high, which is inactive.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rts_n_r <= 1'b1;
      dtr_n_r <= 1'b1;
    end else if (loop_on) begin
      rts_n_r <= 1'b1;
      dtr_n_r <= 1'b1;
    end else begin
      rts_n_r <= ~rts_int;
      dtr_n_r <= ~mlc_r[UMC_DTR_BIT];
    end
  end

  // Transmit permission, checked by the transmitter before each
  // character. The receiver is never blocked by negated RTS, so a
  // late character from the far end still lands while space lasts.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_start_ok_r <= 1'b1;
    end else begin
      tx_start_ok_r <= ~acts_on | mls_nxt[0];
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign rx_serial = rx_serial_r;
  assign tx_start_ok = tx_start_ok_r;
  assign modem_line_state = mls_r;
  assign txd_pin = txd_r;
  assign rts_n_pin = rts_n_r;
  assign dtr_n_pin = dtr_n_r;
  assign irq = irq_r;

endmodule // umc_modem_ctrl

// ---- verif/umc_remote.sv ----
// Purpose: Remote UART model facing the modem pins.
// Assumes: Same clock as the block; one bit lasts four cycles.
// Notes: Sends a counting byte whenever RTS is low.
module umc_remote (
  input wire logic aclk,
  input wire logic rts_n_pin,
  input wire logic stop_tx,
  output logic cts_n_pin,
  output logic rxd_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] frame_r = 10'h000; // Bits still to send, start first.
  logic [7:0] byte_r = 8'h00; // Next character value.
  logic [1:0] tick_r = 2'h0; // Bit time prescaler.
  initial begin
    cts_n_pin = 1'b1;
    rxd_pin = 1'b1;
  end
  // CTS is raised from a register, well before any stop bit centre.
  always @(posedge aclk) cts_n_pin <= stop_tx;
  // A character already begun is finished even if RTS rises meanwhile.
  always @(posedge aclk) begin
    tick_r <= tick_r + 2'h1;
    if (tick_r == 2'h3) begin
      if (frame_r != 10'h000) begin
        rxd_pin <= frame_r[0];
        frame_r <= frame_r >> 1;
      end else if (!rts_n_pin) begin
        frame_r <= {1'b1, byte_r, 1'b0};
        byte_r <= byte_r + 8'h01;
      end else begin
        rxd_pin <= 1'b1; // The idle line rests at the marking level.
      end
    end
  end
endmodule // umc_remote

// ---- verif/umc_modem_ctrl_properties.sv ----
// Purpose: Port-level checks of the modem control block.
// Assumes: One clock; the control mirror trails the design by one edge.
// Notes: The mirror follows control writes seen on the register bus.
module umc_modem_ctrl_properties
  import umc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [UMC_LVL_W-1:0] rx_level,
  input wire logic [1:0] rx_trig,
  input wire logic tx_serial,
  input wire logic rx_serial,
  input wire logic tx_start_ok,
  input wire logic [3:0] modem_line_state,
  input wire logic cts_n_pin,
  input wire logic txd_pin,
  input wire logic rts_n_pin,
  input wire logic dtr_n_pin,
  input wire logic irq
);
  localparam logic [5:0] HI_T [4] = '{UMC_TRIG_C0, UMC_TRIG_C1,
    UMC_TRIG_C2, UMC_TRIG_C3};
  localparam logic [5:0] LO_T [4] = '{UMC_LVL_EMPTY, UMC_TRIG_C0,
    UMC_TRIG_C1, UMC_TRIG_C2};
  logic aw_hit_r, w_ok_r; // The pending write targets the control word.
  logic [7:0] wd_r; // Stored bits of the pending write.
  logic [7:0] mlc_m; // Mirror of the control word.
  logic loop_on, auto_on, man_on, cts_on;
  // A write lands in the mirror when its response first shows.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hit_r <= 1'b0;
      w_ok_r <= 1'b0;
      wd_r <= 8'h00;
      mlc_m <= 8'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready)
        aw_hit_r <= (s_axi_awaddr == UMC_MLC_ADDR);
      if (s_axi_wvalid && s_axi_wready) begin
        wd_r <= s_axi_wdata[7:0] & UMC_MLC_STORE_MASK;
        w_ok_r <= s_axi_wstrb[0];
      end
      // The RTS bit keeps its value while auto RTS owns the pin.
      if ($rose(s_axi_bvalid) && aw_hit_r && w_ok_r)
        mlc_m <= {wd_r[7:2], mlc_m[6] ? mlc_m[1] : wd_r[1], wd_r[0]};
    end
  end
  assign loop_on = mlc_m[UMC_LOOP_BIT];
  assign auto_on = mlc_m[UMC_ARTS_BIT] && !loop_on;
  assign man_on = !mlc_m[UMC_ARTS_BIT] && !loop_on;
  assign cts_on = mlc_m[UMC_ACTS_BIT] && !loop_on;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_full;
    auto_on && rx_level >= HI_T[rx_trig] ##1 auto_on ##1 auto_on;
  endsequence
  sequence s_drain;
    auto_on && rx_level <= LO_T[rx_trig] ##1 auto_on ##1 auto_on;
  endsequence
  sequence s_cts_high;
    (cts_on && cts_n_pin)[*3] ##1 cts_on;
  endsequence
  AST_RESET_IDLE: assert property ($rose(aresetn) |-> txd_pin &&
    rts_n_pin && dtr_n_pin && tx_start_ok && !irq)
    else $error("outputs not idle after reset");
  AST_LOOP_TXD: assert property (loop_on |-> txd_pin)
    else $error("serial output not marking in loopback");
  AST_LOOP_OUTS: assert property (loop_on |-> rts_n_pin && dtr_n_pin)
    else $error("modem outputs active in loopback");
  AST_LOOP_RX: assert property (loop_on |->
    rx_serial == $past(tx_serial))
    else $error("receiver not fed from transmitter in loopback");
  AST_LOOP_STATE: assert property (loop_on && !mlc_m[UMC_ARTS_BIT]
    |-> modem_line_state == {mlc_m[3], mlc_m[2], mlc_m[0], mlc_m[1]})
    else $error("modem state not taken from control bits");
  // The first edge after reset still shows the reset value of TXD.
  AST_TXD_FOLLOW: assert property (!loop_on && $past(aresetn) |->
    txd_pin == $past(tx_serial))
    else $error("serial output does not follow the transmitter");
  AST_RTS_MANUAL: assert property (man_on |->
    rts_n_pin == !mlc_m[UMC_RTS_BIT])
    else $error("RTS pin does not follow the control bit");
  AST_AUTO_NEGATE: assert property (s_full |-> rts_n_pin)
    else $error("RTS not negated at trigger level");
  AST_AUTO_REASSERT: assert property (s_drain |-> !rts_n_pin)
    else $error("RTS not reasserted at lower level");
  AST_CTS_GATE: assert property (s_cts_high |-> !tx_start_ok)
    else $error("transmitter allowed to start with CTS high");
endmodule // umc_modem_ctrl_properties

bind umc_modem_ctrl umc_modem_ctrl_properties umc_modem_ctrl_properties_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .rx_level(rx_level), .rx_trig(rx_trig),
  .tx_serial(tx_serial), .rx_serial(rx_serial), .tx_start_ok(tx_start_ok),
  .modem_line_state(modem_line_state), .cts_n_pin(cts_n_pin),
  .txd_pin(txd_pin), .rts_n_pin(rts_n_pin), .dtr_n_pin(dtr_n_pin),
  .irq(irq));

// ---- verif/tb.sv ----
// Purpose: Self-checking bench for the modem control block.
// Assumes: Read results are scored in order through a queue.
// Notes: Modem pins other than CTS idle high; the remote owns CTS and RXD.
module tb
  import umc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, tx_serial = 1'b1, stop_tx = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
  logic [31:0] s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [5:0] rx_level = 6'h00;
  logic [1:0] rx_trig = 2'h0;
  logic dsr_n_pin = 1'b1, ri_n_pin = 1'b1, dcd_n_pin = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, rx_serial, tx_start_ok, rxd_pin, cts_n_pin;
  logic txd_pin, rts_n_pin, dtr_n_pin, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [3:0] modem_line_state;
  int errors = 0, total_checks = 0, seed = 78;
  logic [33:0] want_q[$]; // Expected {rresp, rdata}, oldest first.
  logic [5:0] hi_t [4] = '{6'h01, 6'h10, 6'h18, 6'h1c}; // Negate levels.
  logic [5:0] lo_t [4] = '{6'h00, 6'h01, 6'h10, 6'h18}; // Reassert levels.

  umc_modem_ctrl umc_modem_ctrl_inst (.*);
  umc_remote umc_remote_inst (.*);

  always #5 aclk = ~aclk;
  // Random serial traffic keeps the loopback path busy.
  always @(posedge aclk) tx_serial <= 1'($random(seed));

  task automatic results;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    total_checks++;
    if (seen !== want) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  // Address and data are offered together and dropped when each is taken.
  task automatic wr(input logic [31:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 40);
    s_axi_bready <= 1'b0;
    if (n >= 40) begin
      errors++;
      results();
    end
  endtask

  // The expectation is queued first; the monitor scores the answer.
  task automatic rd(input logic [31:0] a, input logic [33:0] e);
    int n;
    want_q.push_back(e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 40);
    s_axi_rready <= 1'b0;
    if (n >= 40) begin
      errors++;
      results();
    end
  endtask

  // Decider and pin each take one edge, so four edges is ample.
  task automatic lvl(input logic [5:0] v, input logic e);
    rx_level <= v;
    repeat (4) @(posedge aclk);
    check({33'h0, rts_n_pin}, {33'h0, e});
  endtask

  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      if (want_q.size() == 0) check(34'h1, 34'h0);
      else check({s_axi_rresp, s_axi_rdata}, want_q.pop_front());
    end
  end

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(UMC_MLC_ADDR, 34'h0);
    rd(32'h80101000, {UMC_RESP_SLVERR, 32'h0});
    wr(UMC_MLC_ADDR, 32'h2, 4'h1);
    rd(UMC_MLC_ADDR, 34'h2);
    check({33'h0, rts_n_pin}, 34'h0);
    wr(UMC_MLC_ADDR, 32'h0, 4'h0);
    rd(UMC_MLC_ADDR, 34'h2);
    wr(UMC_MLC_ADDR, 32'h0, 4'h1);
    repeat (2) @(posedge aclk);
    check({33'h0, rts_n_pin}, 34'h1);
    // Loopback: control writes turn into modem state events.
    wr(UMC_MLC_ADDR, 32'h10, 4'h1);
    wr(UMC_EVT_CLR_ADDR, 32'h1f, 4'h1);
    wr(UMC_EVT_EN_ADDR, 32'hf, 4'h1);
    wr(UMC_MLC_ADDR, 32'h1f, 4'h1);
    rd(UMC_MLC_ADDR, 34'h10);
    check({30'h0, modem_line_state}, 34'hf);
    check({31'h0, txd_pin, rts_n_pin, dtr_n_pin}, 34'h7);
    // Modem input pins move in loopback and must not reach the state.
    {dcd_n_pin, ri_n_pin, dsr_n_pin} <= 3'h0;
    stop_tx <= 1'b1;
    repeat (4) @(posedge aclk);
    check({30'h0, modem_line_state}, 34'hf);
    {dcd_n_pin, ri_n_pin, dsr_n_pin} <= 3'h7;
    stop_tx <= 1'b0;
    rd(UMC_EVT_STAT_ADDR, 34'hf);
    check({33'h0, irq}, 34'h1);
    wr(UMC_EVT_CLR_ADDR, 32'h1f, 4'h1);
    repeat (2) @(posedge aclk);
    check({33'h0, irq}, 34'h0);
    wr(UMC_EVT_EN_ADDR, 32'h0, 4'h1);
    wr(UMC_MLC_ADDR, 32'h10, 4'h1);
    rd(UMC_EVT_STAT_ADDR, 34'hf);
    check({33'h0, irq}, 34'h0);
    // Auto RTS over every trigger code, with hysteresis both ways.
    wr(UMC_MLC_ADDR, 32'h0, 4'h1);
    wr(UMC_EVT_CLR_ADDR, 32'h1f, 4'h1);
    wr(UMC_EVT_EN_ADDR, 32'h10, 4'h1);
    check({30'h0, modem_line_state}, 34'h1);
    wr(UMC_MLC_ADDR, 32'h40, 4'h1);
    for (int c = 0; c < 4; c++) begin
      rx_trig <= 2'(c);
      lvl(lo_t[c], 1'b0);
      lvl(hi_t[c] - 6'h01, 1'b0);
      lvl(hi_t[c], 1'b1);
      rd(UMC_MLC_ADDR, 34'h40);
      lvl(lo_t[c] + 6'h01, 1'b1);
      lvl(lo_t[c], 1'b0);
      rd(UMC_MLC_ADDR, 34'h42);
    end
    check({33'h0, irq}, 34'h1);
    rd(UMC_EVT_STAT_ADDR, 34'h10);
    rx_level <= 6'h00;
    wr(UMC_MLC_ADDR, 32'h80, 4'h1);
    stop_tx <= 1'b1;
    repeat (8) @(posedge aclk);
    check({33'h0, tx_start_ok}, 34'h0);
    stop_tx <= 1'b0;
    repeat (8) @(posedge aclk);
    check({33'h0, tx_start_ok}, 34'h1);
    rd(UMC_MLC_ADDR, 34'h80);
    results();
  end
endmodule // tb
